// >>> core/boot_select_pkg.sv
// shared constants for the dual bank boot select block
package boot_select_pkg;
  localparam logic [19:0] BANK0_BASE     = 20'h00000;
  localparam logic [19:0] FLAG_OFFSET    = 20'h00008;
  localparam logic [7:0]  FLAG_VALID     = 8'h4B;
  localparam logic [7:0]  FLAG_CLEARED   = 8'h00;
  localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
  localparam logic [19:0] BANK1_BASE_128 = 20'h20000;
  localparam logic [19:0] BANK1_BASE_256 = 20'h40000;
  localparam logic [19:0] BANK1_BASE_512 = 20'h80000;
  // one erase strobe clears a sector; byte erase kept banks busy too long
  localparam logic [19:0] ERASE_STEP     = 20'h01000;
  // bank size select codes and image size limits in kilobytes
  localparam logic [1:0]  SEL_128        = 2'h0;
  localparam logic [1:0]  SEL_256        = 2'h1;
  localparam logic [1:0]  SEL_512        = 2'h2;
  localparam logic [1:0]  SEL_DEFAULT    = SEL_256;
  localparam logic [9:0]  MAX_KB_128     = 10'd124;
  localparam logic [9:0]  MAX_KB_256     = 10'd252;
  localparam logic [9:0]  MAX_KB_512     = 10'd508;
  // command opcodes and payload limit
  localparam logic [15:0] OP_START       = 16'h0001;
  localparam logic [15:0] OP_END         = 16'h0002;
  localparam logic [4:0]  CMD_DATA_MAX   = 5'd18;
  // result codes
  localparam logic [7:0]  RES_SUCCESS    = 8'h00;
  localparam logic [7:0]  RES_SEQ_ERR    = 8'h01;
  localparam logic [7:0]  RES_INVALID    = 8'h02;
  localparam logic [7:0]  RES_CRC_ERR    = 8'h03;
  // update timeout
  localparam int          CLK_HZ         = 25_000_000;
  localparam int          TIMEOUT_MS     = 1000;
  localparam int          TIMEOUT_CYCLES = CLK_HZ / 1000 * TIMEOUT_MS;
  localparam int          FIFO_DEPTH     = 4;
endpackage

// >>> core/byte_stream_if.sv
// valid/ready byte stream between the loader and its fifo
`timescale 1ns/1ps
interface byte_stream_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// >>> core/image_fifo.sv
// small parameterised fifo for image data bytes
`timescale 1ns/1ps
module image_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             in_ready,
  // draining side
  byte_stream_if.src            out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0]      count, next_count;
  logic             push, pop;

  always_comb begin
    push        = in_valid && (count != (AW+1)'(DEPTH));
    pop         = out.ready && (count != '0);
    next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1)
                       : wr_ptr;
    next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1)
                      : rd_ptr;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // storage has no reset, contents qualified by count
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // room after this edge, so the user may register it as its ready
  assign in_ready  = (next_count != (AW+1)'(DEPTH));
  assign out.valid = (count != '0);
  assign out.data  = mem[rd_ptr];
endmodule

// >>> core/dual_bank_boot_select.sv
// boot bank selection and update bank swap controller
//
// Operation
// - try bank 0 flag at 0x08 first
// - else check second bank flag, boot there if valid, else bank 0
// - selection done by hardware, no software
// - report booted bank and idle offset
// - erase idle bank to 0xff at init
// - store image bytes sequentially in idle bank
// - end: set new flag 0x4b, old 0x00
// - notify result, then request reboot
// - timer, errors or timeout fail and reboot
// - second bank at 128K, 256K or 512K
// - default banks 0 and 0x40000, 252K
// - bank config latched only before init
// - start command enters update mode
// - command: two octet opcode, 0-18 data octets
// - result report always present
// - result codes 0x00 to 0x03
`timescale 1ns/1ps
module dual_bank_boot_select
  import boot_select_pkg::*;
#(
  parameter int TIMEOUT = TIMEOUT_CYCLES
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // bank configuration, sampled once
  input  wire logic [1:0]  bank_cfg,
  // flash byte port
  output      logic        flash_rd,
  output      logic        flash_wr,
  output      logic        flash_erase,
  output      logic [19:0] flash_addr,
  output      logic [7:0]  flash_wdata,
  input  wire logic        flash_done,
  input  wire logic [7:0]  flash_rdata,
  // commands from update master
  input  wire logic        cmd_valid,
  input  wire logic [15:0] cmd_opcode,
  input  wire logic [4:0]  cmd_len,
  input  wire logic [15:0] cmd_index_max,
  input  wire logic [15:0] cmd_index_xor,
  // image data from update master
  input  wire logic        data_valid,
  input  wire logic [7:0]  data_byte,
  input  wire logic        data_seq_err,
  input  wire logic        data_crc_err,
  output      logic        data_ready,
  // status and results
  output      logic        boot_done,
  output      logic        boot_bank,
  output      logic [19:0] fetch_base,
  output      logic [19:0] store_offset,
  output      logic [9:0]  max_image_kb,
  output      logic        update_active,
  output      logic        result_valid,
  output      logic [7:0]  result_code,
  output      logic        reboot_req
);
  typedef enum {
    ST_CFG, ST_RD0, ST_RD1, ST_ERASE, ST_IDLE, ST_UPDATE, ST_WRNEW,
    ST_WROLD, ST_REPORT, ST_REBOOT
  } state_e;

  byte_stream_if    fifo_out ();
  logic             fifo_ready;
  state_e           state, next_state;
  logic [19:0]      bank1, next_bank1;
  logic             bank, next_bank;
  logic [19:0]      addr, next_addr;
  logic [19:0]      wptr, next_wptr;
  logic [31:0]      timer, next_timer;
  logic [7:0]       code, next_code;
  logic             rd, next_rd, wr, next_wr, er, next_er;
  logic [7:0]       wdata, next_wdata;
  logic             busy, next_busy;
  logic             done_q, next_done;
  logic             upd, next_upd;
  logic             res_v, next_res_v;
  logic             rbt, next_rbt;
  logic [9:0]       kb, next_kb;
  logic             cmd_ok, fail;
  logic [19:0]      idle_base, bank_end;

  //////////////////////////////////////////////////////////////////////////
  // data path buffer; stalls the master while flash writes are slow
  image_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .in_valid (data_valid && data_ready),
    .in_data  (data_byte),
    .in_ready (fifo_ready),
    .out      (fifo_out)
  );

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    idle_base = bank ? BANK0_BASE : bank1;
    bank_end  = bank ? bank1 : (bank1 + bank1);
    cmd_ok = (cmd_len <= CMD_DATA_MAX);
    fail = data_seq_err || data_crc_err || (timer >= 32'(TIMEOUT))
           || (cmd_valid && !cmd_ok);
  end

  always_comb begin
    next_state = state;
    next_bank1 = bank1;
    next_bank  = bank;
    next_addr  = addr;
    next_wptr  = wptr;
    next_timer = timer;
    next_code  = code;
    next_rd    = 1'b0;
    next_wr    = 1'b0;
    next_er    = 1'b0;
    next_wdata = wdata;
    next_busy  = busy && !flash_done;
    next_done  = done_q;
    next_upd   = upd;
    next_res_v = 1'b0;
    next_rbt   = rbt;
    next_kb    = kb;
    fifo_out.ready = 1'b0;
    case (state)
      ST_CFG: begin
        case (bank_cfg)
          SEL_128: begin
            next_bank1 = BANK1_BASE_128;
            next_kb    = MAX_KB_128;
          end
          SEL_512: begin
            next_bank1 = BANK1_BASE_512;
            next_kb    = MAX_KB_512;
          end
          default: begin
            next_bank1 = BANK1_BASE_256;
            next_kb    = MAX_KB_256;
          end
        endcase
        next_addr  = BANK0_BASE + FLAG_OFFSET;
        next_rd    = 1'b1;
        next_busy  = 1'b1;
        next_state = ST_RD0;
      end
      ST_RD0: begin
        if (flash_done) begin
          if (flash_rdata == FLAG_VALID) begin
            next_bank  = 1'b0;
            next_state = ST_ERASE;
            next_addr  = bank1;
          end else begin
            next_addr  = bank1 + FLAG_OFFSET;
            next_rd    = 1'b1;
            next_busy  = 1'b1;
            next_state = ST_RD1;
          end
        end
      end
      ST_RD1: begin
        if (flash_done) begin
          next_bank  = (flash_rdata == FLAG_VALID);
          next_addr  = (flash_rdata == FLAG_VALID) ? BANK0_BASE : bank1;
          next_state = ST_ERASE;
        end
      end
      ST_ERASE: begin
        // idle bank erased sector by sector to 0xff
        next_done = 1'b1;
        if (!busy && !er) begin
          if (addr == bank_end) begin
            next_wptr  = idle_base;
            next_state = ST_IDLE;
          end else begin
            next_er   = 1'b1;
            next_busy = 1'b1;
          end
        end else if (busy && flash_done) begin
          next_addr = addr + ERASE_STEP;
        end
      end
      ST_IDLE: begin
        if (cmd_valid && cmd_ok && cmd_opcode == OP_START) begin
          next_upd   = 1'b1;
          next_timer = '0;
          next_wptr  = idle_base;
          next_state = ST_UPDATE;
        end
      end
      ST_UPDATE: begin
        next_timer = timer + 32'h1;
        if (fail) begin
          next_code  = data_crc_err ? RES_CRC_ERR
                     : data_seq_err ? RES_SEQ_ERR : RES_INVALID;
          next_upd   = 1'b0;
          next_state = ST_REPORT;
        end else if (!busy && !wr && fifo_out.valid) begin
          fifo_out.ready = 1'b1;
          next_addr  = wptr;
          next_wdata = fifo_out.data;
          next_wr    = 1'b1;
          next_busy  = 1'b1;
          next_wptr  = wptr + 20'h1;
          next_timer = '0;
        end else if (!busy && !wr && !fifo_out.valid && cmd_valid
                     && cmd_opcode == OP_END) begin
          // index check word verified when present
          if (cmd_len >= 5'h04 && (cmd_index_max ^ cmd_index_xor) != 16'hFFFF)
          begin
            next_code  = RES_INVALID;
            next_state = ST_REPORT;
          end else begin
            next_code  = RES_SUCCESS;
            next_state = ST_WRNEW;
            next_addr  = idle_base + FLAG_OFFSET;
            next_wdata = FLAG_VALID;
            next_wr    = 1'b1;
            next_busy  = 1'b1;
          end
          next_upd = 1'b0;
        end
      end
      ST_WRNEW: begin
        // new bank flag then old bank flag
        if (busy && flash_done) begin
          next_addr  = (bank ? bank1 : BANK0_BASE) + FLAG_OFFSET;
          next_wdata = FLAG_CLEARED;
          next_wr    = 1'b1;
          next_state = ST_WROLD;
        end
      end
      ST_WROLD: begin
        if (!busy && !wr) begin
          next_state = ST_REPORT;
        end
      end
      ST_REPORT: begin
        if (!busy) begin
          next_res_v = 1'b1;
          next_state = ST_REBOOT;
        end
      end
      ST_REBOOT: begin
        next_rbt = 1'b1;
      end
      default: next_state = ST_CFG;
    endcase
    if (next_wr && state == ST_WRNEW) begin
      next_busy = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state  <= ST_CFG;
      bank1  <= BANK1_BASE_256;
      bank   <= 1'b0;
      addr   <= '0;
      wptr   <= '0;
      timer  <= '0;
      code   <= RES_SUCCESS;
      rd     <= 1'b0;
      wr     <= 1'b0;
      er     <= 1'b0;
      wdata  <= '0;
      busy   <= 1'b0;
      done_q <= 1'b0;
      upd    <= 1'b0;
      res_v  <= 1'b0;
      rbt    <= 1'b0;
      kb     <= MAX_KB_256;
    end else begin
      state  <= next_state;
      bank1  <= next_bank1;
      bank   <= next_bank;
      addr   <= next_addr;
      wptr   <= next_wptr;
      timer  <= next_timer;
      code   <= next_code;
      rd     <= next_rd;
      wr     <= next_wr;
      er     <= next_er;
      wdata  <= next_wdata;
      busy   <= next_busy;
      done_q <= next_done;
      upd    <= next_upd;
      res_v  <= next_res_v;
      rbt    <= next_rbt;
      kb     <= next_kb;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // booted bank and idle offset shown
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_base   <= '0;
      store_offset <= '0;
      data_ready   <= 1'b0;
    end else begin
      fetch_base   <= bank ? bank1 : BANK0_BASE;
      store_offset <= idle_base;
      data_ready   <= fifo_ready && next_upd;
    end
  end

  assign flash_rd      = rd;
  assign flash_wr      = wr;
  assign flash_erase   = er;
  assign flash_addr    = addr;
  assign flash_wdata   = wdata;
  assign boot_done     = done_q;
  assign boot_bank     = bank;
  assign max_image_kb  = kb;
  assign update_active = upd;
  assign result_valid  = res_v;
  assign result_code   = code;
  assign reboot_req    = rbt;
endmodule

// >>> verification/boot_select_props.sv
// checker for the boot bank select block
`timescale 1ns/1ps
module boot_select_props
  import boot_select_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // flash side
  input wire logic        flash_rd,
  input wire logic        flash_erase,
  input wire logic [19:0] flash_addr,
  // status
  input wire logic        boot_done,
  input wire logic        boot_bank,
  input wire logic [19:0] fetch_base,
  input wire logic [19:0] store_offset,
  input wire logic [9:0]  max_image_kb,
  input wire logic        update_active,
  input wire logic        data_ready,
  input wire logic        result_valid,
  input wire logic        reboot_req
);
  logic        told;
  logic        next_told;
  logic [19:0] hi;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // bank size follows the latched limit
  assign hi = max_image_kb == MAX_KB_128 ? BANK1_BASE_128 :
              max_image_kb == MAX_KB_512 ? BANK1_BASE_512 : BANK1_BASE_256;
  always_comb next_told = told | result_valid;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) told <= 1'b0;
    else told <= next_told;
  end
  ////////////////////////////////////////
  a_flag_first: assert property (
    $rose(rst_n) |-> ##[0:2] flash_rd && flash_addr == FLAG_OFFSET)
    else $error("first read is not the bank 0 flag");
  a_fetch_base: assert property (
    boot_done |-> fetch_base == (boot_bank ? hi : BANK0_BASE))
    else $error("fetch base wrong");
  a_store_idle: assert property (
    boot_done |-> store_offset == (boot_bank ? BANK0_BASE : hi))
    else $error("store offset not the idle bank");
  a_size_locked: assert property (
    boot_done && $past(boot_done) |-> $stable(max_image_kb))
    else $error("bank size changed after boot");
  a_erase_idle: assert property (
    flash_erase |-> boot_done && flash_addr - store_offset < hi)
    else $error("erase outside the idle bank");
  a_ready_update: assert property (
    data_ready |-> update_active)
    else $error("data taken outside update mode");
  a_reboot_held: assert property (
    reboot_req |=> reboot_req)
    else $error("reboot request dropped");
  a_result_reboot: assert property (
    result_valid |-> ##[0:3] reboot_req)
    else $error("no reboot after result");
  a_result_once: assert property (
    result_valid |-> !told)
    else $error("result reported twice");
endmodule
bind dual_bank_boot_select boot_select_props chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .flash_rd(flash_rd),
  .flash_erase(flash_erase), .flash_addr(flash_addr),
  .boot_done(boot_done), .boot_bank(boot_bank), .fetch_base(fetch_base),
  .store_offset(store_offset), .max_image_kb(max_image_kb),
  .update_active(update_active), .data_ready(data_ready),
  .result_valid(result_valid), .reboot_req(reboot_req));

// >>> verification/flash_model.sv
// behavioural flash holding both image banks
`timescale 1ns/1ps
module flash_model
  import boot_select_pkg::*;
(
  // clock
  input wire logic        sys_clk,
  // byte port
  input wire logic        flash_rd,
  input wire logic        flash_wr,
  input wire logic        flash_erase,
  input wire logic [19:0] flash_addr,
  input wire logic [7:0]  flash_wdata,
  output     logic        flash_done = 1'b0,
  output     logic [7:0]  flash_rdata = 8'h00
);
  logic [7:0]  mem [logic [19:0]];
  logic [19:0] a;
  logic [7:0]  w;
  logic        wr;
  logic        er;
  int          lat = 1;
  int          wr_cnt = 0;
  function automatic logic [7:0] rd(input logic [19:0] x);
    return mem.exists(x) ? mem[x] : 8'hFF;
  endfunction
  always @(posedge sys_clk) begin
    flash_done <= 1'b0;
    // toggling bus, no stale byte between answers
    flash_rdata <= ~flash_rdata;
    if (flash_rd || flash_wr || flash_erase) begin
      a = flash_addr;
      w = flash_wdata;
      wr = flash_wr;
      er = flash_erase;
      repeat (lat) @(posedge sys_clk);
      if (wr) begin
        mem[a] = w;
        wr_cnt++;
      end
      else if (er) begin
        for (int i = 0; i < int'(ERASE_STEP); i++) mem.delete(a + 20'(i));
      end
      flash_rdata <= rd(a);
      flash_done <= 1'b1;
    end
  end
endmodule

// >>> verification/tb_top.sv
// self-checking bench for the boot bank select block
`timescale 1ns/1ps
module tb_top
  import boot_select_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [1:0]  bank_cfg = 2'h0;
  logic        cmd_valid = 1'b0;
  logic [15:0] cmd_opcode = 16'h0000;
  logic [4:0]  cmd_len = 5'h04;
  logic [15:0] cmd_index_max = 16'h0005;
  logic [15:0] cmd_index_xor = 16'hFFFA;
  logic        data_valid = 1'b0;
  logic [7:0]  data_byte = 8'h00;
  logic        data_seq_err = 1'b0;
  logic        data_crc_err = 1'b0;
  logic        flash_rd, flash_wr, flash_erase, flash_done, data_ready;
  logic        boot_done, boot_bank, update_active, result_valid, reboot_req;
  logic [19:0] flash_addr, fetch_base, store_offset;
  logic [7:0]  flash_wdata, flash_rdata, result_code;
  logic [9:0]  max_image_kb;
  logic        stalled = 1'b0;
  int          failures = 0;
  int          comparisons = 0;
  int          cyc = 0;
  always #20 sys_clk = ~sys_clk;
  dual_bank_boot_select #(.TIMEOUT(200)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .bank_cfg(bank_cfg),
    .flash_rd(flash_rd), .flash_wr(flash_wr), .flash_erase(flash_erase),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_done(flash_done), .flash_rdata(flash_rdata),
    .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_len(cmd_len),
    .cmd_index_max(cmd_index_max), .cmd_index_xor(cmd_index_xor),
    .data_valid(data_valid), .data_byte(data_byte),
    .data_seq_err(data_seq_err), .data_crc_err(data_crc_err),
    .data_ready(data_ready), .boot_done(boot_done), .boot_bank(boot_bank),
    .fetch_base(fetch_base), .store_offset(store_offset),
    .max_image_kb(max_image_kb), .update_active(update_active),
    .result_valid(result_valid), .result_code(result_code),
    .reboot_req(reboot_req));
  flash_model fl (
    .sys_clk(sys_clk), .flash_rd(flash_rd), .flash_wr(flash_wr),
    .flash_erase(flash_erase), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .flash_done(flash_done),
    .flash_rdata(flash_rdata));
  ////////////////////////////////////////
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // each bank erase is a few hundred cycles of sector strobes
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      summarize();
    end
  end
  task automatic send_cmd(input logic [15:0] op);
    @(negedge sys_clk);
    cmd_opcode = op;
    cmd_valid = 1'b1;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
  endtask
  task automatic wait_result;
    int k;
    for (k = 0; k < 300 && result_valid !== 1'b1; k++) @(negedge sys_clk);
    check(20'(result_valid), 20'h1);
    repeat (4) @(negedge sys_clk);
    check(20'(reboot_req), 20'h1);
  endtask
  task automatic start_update;
    int k;
    // start is ignored while the idle bank is erasing
    for (k = 0; k < 300000 && update_active !== 1'b1; k++) send_cmd(OP_START);
    check(20'(update_active), 20'h1);
  endtask
  task automatic send_bytes(input int n);
    int i;
    int k;
    for (i = 0; i < n; i++) begin
      data_byte = 8'(8'hA0 + i);
      data_valid = 1'b1;
      for (k = 0; k < 100 && data_ready !== 1'b1; k++) @(negedge sys_clk);
      if (k > 0) stalled = 1'b1;
      @(negedge sys_clk);
    end
    data_valid = 1'b0;
  endtask
  task automatic t_boot(input logic [7:0] f0, input logic [7:0] f1,
                        input logic [1:0] cfg, input logic eb);
    logic [19:0] hi;
    logic [9:0]  kb;
    int          k;
    hi = cfg == SEL_128 ? BANK1_BASE_128 :
         cfg == SEL_512 ? BANK1_BASE_512 : BANK1_BASE_256;
    kb = cfg == SEL_128 ? MAX_KB_128 :
         cfg == SEL_512 ? MAX_KB_512 : MAX_KB_256;
    @(negedge sys_clk);
    rst_n = 1'b0;
    bank_cfg = cfg;
    repeat (16) @(negedge sys_clk);
    // flags planted only after any flash op cut by reset has ended
    fl.mem.delete();
    fl.lat = 1;
    fl.mem[FLAG_OFFSET] = f0;
    fl.mem[hi + FLAG_OFFSET] = f1;
    check(20'(max_image_kb), 20'(MAX_KB_256));
    rst_n = 1'b1;
    for (k = 0; k < 50 && boot_done !== 1'b1; k++) @(negedge sys_clk);
    check(20'(boot_bank), 20'(eb));
    check(fetch_base, eb ? hi : BANK0_BASE);
    check(store_offset, eb ? BANK0_BASE : hi);
    check(20'(max_image_kb), 20'(kb));
    bank_cfg = ~cfg;
    repeat (3) @(negedge sys_clk);
    check(20'(max_image_kb), 20'(kb));
    $display("boot test done, cfg %0d", cfg);
  endtask
  task automatic t_update;
    int k;
    t_boot(FLAG_VALID, 8'h5A, SEL_128, 1'b0);
    start_update();
    check(20'(fl.rd(20'h20008)), 20'(ERASED_BYTE));
    fl.lat = 3;
    fl.wr_cnt = 0;
    send_bytes(6);
    check(20'(stalled), 20'h1);
    // end only once every byte landed
    for (k = 0; k < 300 && fl.wr_cnt < 6; k++) @(negedge sys_clk);
    for (k = 0; k < 6; k++) begin
      check(20'(fl.rd(20'h20000 + 20'(k))), 20'(8'hA0 + k));
    end
    send_cmd(OP_END);
    wait_result();
    check(20'(result_code), 20'(RES_SUCCESS));
    check(20'(fl.rd(20'h20008)), 20'(FLAG_VALID));
    check(20'(fl.rd(FLAG_OFFSET)), 20'(FLAG_CLEARED));
    $display("update test done");
  endtask
  task automatic t_fail;
    t_boot(FLAG_CLEARED, FLAG_VALID, SEL_128, 1'b1);
    check(20'(data_ready), 20'h0);
    start_update();
    send_bytes(2);
    repeat (20) @(negedge sys_clk);
    check(20'(fl.rd(BANK0_BASE)), 20'h0A0);
    data_crc_err = 1'b1;
    @(negedge sys_clk);
    data_crc_err = 1'b0;
    wait_result();
    check(20'(result_code), 20'(RES_CRC_ERR));
    check(20'(fl.rd(20'h20008)), 20'(FLAG_VALID));
    check(20'(fl.rd(FLAG_OFFSET)), 20'(ERASED_BYTE));
    $display("failure test done");
  endtask
  task automatic t_timeout;
    t_boot(FLAG_VALID, ERASED_BYTE, SEL_128, 1'b0);
    start_update();
    // no data after start, so the update timer runs out
    wait_result();
    check(20'(result_code), 20'(RES_INVALID));
    check(20'(fl.rd(FLAG_OFFSET)), 20'(FLAG_VALID));
    $display("timeout test done");
  endtask
  initial begin
    t_boot(FLAG_VALID, ERASED_BYTE, SEL_256, 1'b0);
    t_boot(FLAG_CLEARED, FLAG_VALID, SEL_512, 1'b1);
    t_boot(8'h12, 8'h34, 2'h3, 1'b0);
    t_update();
    t_fail();
    t_timeout();
    summarize();
  end
endmodule
